// ---- dbps_pkg.sv ----
// constants and types shared by the dual-phase buck pwm sequencer
package dbps_pkg;
  localparam int CLK_MHZ = 250;
  // dead time between one drive falling and the other rising
  localparam int DEAD_NS = 30;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  // power-good release delay
  localparam int PG_DELAY_MS = 140;
  localparam int PG_DELAY_CYC = PG_DELAY_MS * CLK_MHZ * 1000;
  // soft-start and soft-stop ramp length, and maximum on-time
  localparam int SS_CYC = 1024;
  localparam int MAX_ON_CYC = 200;
  // synchroniser bit positions
  localparam int NSYNC = 11;
  localparam int S_OSC = 0;
  localparam int S_SYNC = 1;
  localparam int S_LOCK = 2;
  localparam int S_DIS = 3;
  localparam int S_DUTY1 = 4;
  localparam int S_DUTY2 = 5;
  localparam int S_ILIM1 = 6;
  localparam int S_ILIM2 = 7;
  localparam int S_FB1 = 8;
  localparam int S_FB2 = 9;
  localparam int S_ZERO1 = 10;

  typedef enum logic [1:0] {
    PH_LOW = 2'h0,
    PH_DTH = 2'h1,
    PH_HIGH = 2'h3,
    PH_DTL = 2'h2
  } dbps_ph_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_SS1 = 3'h1,
    SQ_SS2 = 3'h3,
    SQ_RUN = 3'h2,
    SQ_STOP2 = 3'h6,
    SQ_STOP1 = 3'h7,
    SQ_WAITZ = 3'h5
  } dbps_seq_t;
endpackage

// ---- dbps_chan_if.sv ----
// signals between the sequencer and one channel's drive stage
`timescale 1ns/1ns
`default_nettype none
interface dbps_chan_if;
  logic start;
  logic ilim;
  logic duty_end;
  logic run;
  logic ls_en;
  logic hs;
  logic ls;
  logic hs_fell;
  modport chan (input start, ilim, duty_end, run, ls_en,
                output hs, ls, hs_fell);
  modport ctrl (output start, ilim, duty_end, run, ls_en,
                input hs, ls, hs_fell);
endinterface
`default_nettype wire

// ---- dbps_chan.sv ----
// one channel's high-side / low-side drive pair with dead time
`timescale 1ns/1ns
`default_nettype none
module dbps_chan #(
  parameter int DEAD = dbps_pkg::DEAD_CYC,
  parameter int MAX_ON = dbps_pkg::MAX_ON_CYC
) (
  input wire logic clk,
  input wire logic rst,
  dbps_chan_if.chan ch
);
  localparam int CW = $clog2(MAX_ON + DEAD + 1);
  dbps_pkg::dbps_ph_t ph, next_ph;
  logic [CW-1:0] cnt, next_cnt;
  logic hs, next_hs, ls, next_ls;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_ph = ph;
    next_cnt = cnt + 1'b1;
    unique case (ph)
      dbps_pkg::PH_LOW: begin
        next_cnt = '0;
        // a tripped valley limit skips the pulse, low side stays on
        if (ch.run && ch.start && !ch.ilim) begin
          next_ph = dbps_pkg::PH_DTH;
        end
      end
      dbps_pkg::PH_DTH: begin
        if (!ch.run) begin
          next_ph = dbps_pkg::PH_LOW;
        end else if (cnt == CW'(DEAD - 1)) begin
          next_ph = dbps_pkg::PH_HIGH;
          next_cnt = '0;
        end
      end
      dbps_pkg::PH_HIGH: begin
        if (!ch.run || ch.duty_end || cnt == CW'(MAX_ON - 1)) begin
          next_ph = dbps_pkg::PH_DTL;
          next_cnt = '0;
        end
      end
      dbps_pkg::PH_DTL: begin
        if (cnt == CW'(DEAD - 1)) begin
          next_ph = dbps_pkg::PH_LOW;
        end
      end
    endcase
    next_hs = next_ph == dbps_pkg::PH_HIGH;
    // low side only in the low phase, so never with the high side
    next_ls = ch.ls_en && next_ph == dbps_pkg::PH_LOW;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph <= dbps_pkg::PH_LOW;
      cnt <= '0;
      hs <= 1'b0;
      ls <= 1'b0;
    end else begin
      ph <= next_ph;
      cnt <= next_cnt;
      hs <= next_hs;
      ls <= next_ls;
    end
  end

  assign ch.hs = hs;
  assign ch.ls = ls;
  assign ch.hs_fell = hs && !next_hs;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pulse_req;
    ph == dbps_pkg::PH_LOW && ch.run && ch.start && !ch.ilim;
  endsequence

  no_overlap_a: assert property (!(hs && ls))
    else $error("high and low drive overlap");
  hs_gap_a: assert property ($rose(hs) |-> !$past(ls, 8))
    else $error("high side rose without dead time");
  skip_a: assert property (
    ph == dbps_pkg::PH_LOW && ch.start && ch.ilim |=> !hs)
    else $error("pulse not skipped under current limit");
  start_a: assert property (
    pulse_req ##1 ch.run [*8] |=> hs)
    else $error("pulse did not start after dead time");
  end_a: assert property (
    hs && ch.duty_end |=> !hs ##[1:9] (ls || !ch.ls_en))
    else $error("pulse end did not hand over to low side");
  max_on_a: assert property (
    ph == dbps_pkg::PH_HIGH |-> cnt < CW'(MAX_ON))
    else $error("maximum on-time exceeded");
endmodule
`default_nettype wire

// ---- dbps_top.sv ----
// dual-phase buck pwm sequencer: clock divide, lockout and sequencing
//
// Overview of operation
// - lockout holds both high-side drives low
// - lockout holds both low-side drives low
// - enable active high, low stops both
// - switching clock is oscillator or external sync (sync_sel) divided by two
// - channel one pulse starts rising edge
// - channel two pulse starts falling edge
// - pulse end swaps high side to low side
// - current limit skips pulse, keeps low side
// - supply below threshold disables both channels
// - lockout latched until rail discharged, then rises
// - enable starts channel one only first
// - lockout recovery restarts channel one first
// - enable cycled: wait output one zero first
// - low side latched low until first fall
// - low side high after soft-stop completes
// - channel two starts after channel one soft-start
// - soft-stop channel two before channel one
// - power-good released after soft-start, regulation, delay
// - complementary drives with non-overlap dead time
`timescale 1ns/1ns
`default_nettype none
module dbps_top #(
  parameter int PG_DELAY = dbps_pkg::PG_DELAY_CYC,
  parameter int SS_LEN = dbps_pkg::SS_CYC,
  parameter int MAX_ON = dbps_pkg::MAX_ON_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic osc_in,
  input wire logic sync_ext,
  input wire logic sync_sel,
  input wire logic supply_lockout,
  input wire logic rail_discharged,
  input wire logic duty_end_ch1,
  input wire logic duty_end_ch2,
  input wire logic ilim_ch1,
  input wire logic ilim_ch2,
  input wire logic fb_ok_ch1,
  input wire logic fb_ok_ch2,
  input wire logic output_level_ch1_zero,
  output logic hs_drive_ch1,
  output logic ls_drive_ch1,
  output logic hs_drive_ch2,
  output logic ls_drive_ch2,
  output logic sw_clk,
  output logic pgood_n_out,
  output logic pgood_n_oe
);
  localparam int NS = dbps_pkg::NSYNC;
  localparam int TW = $clog2(SS_LEN + 1);
  localparam int PW = $clog2(PG_DELAY + 1);

  ////////////////////////////////////////////////////////////////////
  // input synchronisers; only the second stage is used downstream
  logic [NS-1:0] raw, s1, s2;

  assign raw[dbps_pkg::S_OSC] = osc_in;
  assign raw[dbps_pkg::S_SYNC] = sync_ext;
  assign raw[dbps_pkg::S_LOCK] = supply_lockout;
  assign raw[dbps_pkg::S_DIS] = rail_discharged;
  assign raw[dbps_pkg::S_DUTY1] = duty_end_ch1;
  assign raw[dbps_pkg::S_DUTY2] = duty_end_ch2;
  assign raw[dbps_pkg::S_ILIM1] = ilim_ch1;
  assign raw[dbps_pkg::S_ILIM2] = ilim_ch2;
  assign raw[dbps_pkg::S_FB1] = fb_ok_ch1;
  assign raw[dbps_pkg::S_FB2] = fb_ok_ch2;
  assign raw[dbps_pkg::S_ZERO1] = output_level_ch1_zero;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  logic lock_s, dis_s, zero_s, en_s;
  assign lock_s = s2[dbps_pkg::S_LOCK];
  assign dis_s = s2[dbps_pkg::S_DIS];
  assign zero_s = s2[dbps_pkg::S_ZERO1];
  // enable is a plain logic level, taken as synchronous
  assign en_s = en;

  ////////////////////////////////////////////////////////////////////
  // switching clock: toggle on each rise of the selected source
  logic src, src_d, next_src_d, src_rise, next_sw;

  assign src = sync_sel ? s2[dbps_pkg::S_SYNC] : s2[dbps_pkg::S_OSC];
  assign src_rise = src && !src_d;

  always_comb begin
    next_src_d = src;
    next_sw = src_rise ? !sw_clk : sw_clk;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_d <= 1'b0;
      sw_clk <= 1'b0;
    end else begin
      src_d <= next_src_d;
      sw_clk <= next_sw;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // supply lockout latch: trips low, needs a discharge to re-arm
  logic locked, next_locked, dis_seen, next_dis_seen;

  always_comb begin
    next_locked = locked;
    next_dis_seen = dis_seen;
    if (locked && dis_s) begin
      next_dis_seen = 1'b1;
    end
    if (locked && dis_seen && !lock_s && !dis_s) begin
      next_locked = 1'b0;
      next_dis_seen = 1'b0;
    end
    // a new trip wins over a release in the same cycle
    if (lock_s) begin
      next_locked = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // reset behaves as a fresh power-up from a discharged rail
      locked <= 1'b1;
      dis_seen <= 1'b1;
    end else begin
      locked <= next_locked;
      dis_seen <= next_dis_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power sequencer
  dbps_pkg::dbps_seq_t seq, next_seq;
  logic [TW-1:0] tmr, next_tmr;
  logic cycled, next_cycled;
  logic tdone;

  assign tdone = tmr == TW'(SS_LEN - 1);

  always_comb begin
    next_seq = seq;
    next_cycled = cycled;
    if (locked) begin
      next_seq = dbps_pkg::SQ_IDLE;
      next_cycled = 1'b0;
    end else begin
      unique case (seq)
        dbps_pkg::SQ_IDLE: begin
          if (en_s) begin
            next_seq = cycled ? dbps_pkg::SQ_WAITZ : dbps_pkg::SQ_SS1;
          end
        end
        dbps_pkg::SQ_WAITZ: begin
          if (!en_s) begin
            next_seq = dbps_pkg::SQ_IDLE;
          end else if (zero_s) begin
            next_seq = dbps_pkg::SQ_SS1;
            next_cycled = 1'b0;
          end
        end
        dbps_pkg::SQ_SS1: begin
          if (!en_s) begin
            next_seq = dbps_pkg::SQ_STOP1;
          end else if (tdone) begin
            next_seq = dbps_pkg::SQ_SS2;
          end
        end
        dbps_pkg::SQ_SS2: begin
          if (!en_s) begin
            next_seq = dbps_pkg::SQ_STOP2;
          end else if (tdone) begin
            next_seq = dbps_pkg::SQ_RUN;
          end
        end
        dbps_pkg::SQ_RUN: begin
          if (!en_s) begin
            next_seq = dbps_pkg::SQ_STOP2;
          end
        end
        dbps_pkg::SQ_STOP2: begin
          if (tdone) begin
            next_seq = dbps_pkg::SQ_STOP1;
          end
        end
        dbps_pkg::SQ_STOP1: begin
          if (tdone) begin
            next_seq = dbps_pkg::SQ_IDLE;
            next_cycled = 1'b1;
          end
        end
        default: begin
          next_seq = dbps_pkg::SQ_IDLE;
        end
      endcase
    end
    // a ramp restarts on every state change
    next_tmr = (next_seq != seq) ? '0 : tmr + 1'b1;
    if (next_seq == dbps_pkg::SQ_RUN || next_seq == dbps_pkg::SQ_IDLE
        || next_seq == dbps_pkg::SQ_WAITZ) begin
      next_tmr = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq <= dbps_pkg::SQ_IDLE;
      tmr <= '0;
      cycled <= 1'b0;
    end else begin
      seq <= next_seq;
      tmr <= next_tmr;
      cycled <= next_cycled;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channels
  dbps_chan_if chi[2] ();
  logic [1:0] run, park, armed, next_armed, hs, ls, fell;
  logic [1:0] start, ilim, duty;
  logic idle_park;

  assign idle_park = cycled && (seq == dbps_pkg::SQ_IDLE
                     || seq == dbps_pkg::SQ_WAITZ);
  // channel two is off through channel one's soft-start
  assign run[0] = !locked && (seq == dbps_pkg::SQ_SS1
                  || seq == dbps_pkg::SQ_SS2 || seq == dbps_pkg::SQ_RUN
                  || seq == dbps_pkg::SQ_STOP2
                  || seq == dbps_pkg::SQ_STOP1);
  assign run[1] = !locked && (seq == dbps_pkg::SQ_SS2
                  || seq == dbps_pkg::SQ_RUN
                  || seq == dbps_pkg::SQ_STOP2);
  assign park[0] = idle_park;
  assign park[1] = idle_park || seq == dbps_pkg::SQ_STOP1;
  assign start[0] = src_rise && !sw_clk;
  assign start[1] = src_rise && sw_clk;
  assign ilim = {s2[dbps_pkg::S_ILIM2], s2[dbps_pkg::S_ILIM1]};
  assign duty = {s2[dbps_pkg::S_DUTY2], s2[dbps_pkg::S_DUTY1]};

  for (genvar g = 0; g < 2; g++) begin : gch
    assign chi[g].start = start[g];
    assign chi[g].ilim = ilim[g];
    assign chi[g].duty_end = duty[g];
    assign chi[g].run = run[g];
    // low side held off in lockout and until a first pulse ends
    assign chi[g].ls_en = !locked && armed[g]
                          && (run[g] || park[g]);
    assign hs[g] = chi[g].hs;
    assign ls[g] = chi[g].ls;
    assign fell[g] = chi[g].hs_fell;
    // a falling high side wins over a lockout clear
    assign next_armed[g] = fell[g] ? 1'b1 : (locked ? 1'b0 : armed[g]);

    dbps_chan #(
      .DEAD(dbps_pkg::DEAD_CYC),
      .MAX_ON(MAX_ON)
    ) u_chan (
      .clk(clk),
      .rst(rst),
      .ch(chi[g])
    );
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= '0;
    end else begin
      armed <= next_armed;
    end
  end

  assign hs_drive_ch1 = hs[0];
  assign ls_drive_ch1 = ls[0];
  assign hs_drive_ch2 = hs[1];
  assign ls_drive_ch2 = ls[1];

  ////////////////////////////////////////////////////////////////////
  // power-good: open drain, pulled low until regulation plus delay
  logic pg_cond, pg_rel, next_pg_rel;
  logic [PW-1:0] pg_cnt, next_pg_cnt;

  assign pg_cond = !locked && seq == dbps_pkg::SQ_RUN
                   && s2[dbps_pkg::S_FB1] && s2[dbps_pkg::S_FB2];

  always_comb begin
    next_pg_cnt = '0;
    next_pg_rel = 1'b0;
    if (pg_cond) begin
      next_pg_cnt = pg_cnt;
      if (pg_cnt == PW'(PG_DELAY - 1)) begin
        next_pg_rel = 1'b1;
      end else begin
        next_pg_cnt = pg_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pg_cnt <= '0;
      pg_rel <= 1'b0;
    end else begin
      pg_cnt <= next_pg_cnt;
      pg_rel <= next_pg_rel;
    end
  end

  assign pgood_n_out = 1'b0;
  assign pgood_n_oe = !pg_rel;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence soft_stop_done;
    seq == dbps_pkg::SQ_STOP1 && tdone && !locked;
  endsequence

  hs_lock_a: assert property (locked |=> !hs_drive_ch1 && !hs_drive_ch2)
    else $error("high side driven in lockout");
  ls_lock_a: assert property (locked |=> !ls_drive_ch1 && !ls_drive_ch2)
    else $error("low side driven in lockout");
  trip_a: assert property (lock_s |=> locked)
    else $error("lockout not tripped");
  latch_hold_a: assert property (
    locked && !dis_seen && !dis_s |=> locked)
    else $error("lockout released without discharge");
  div_two_a: assert property (
    src_rise |=> sw_clk != $past(sw_clk))
    else $error("switching clock did not toggle");
  ch2_off_a: assert property (
    seq == dbps_pkg::SQ_SS1 && $past(seq) == dbps_pkg::SQ_SS1
    |-> !hs_drive_ch2 && !ls_drive_ch2)
    else $error("channel two active in first soft-start");
  stop_order_a: assert property (
    seq == dbps_pkg::SQ_RUN && !en_s && !locked
    |=> seq == dbps_pkg::SQ_STOP2)
    else $error("soft-stop order wrong");
  zero_wait_a: assert property (
    seq == dbps_pkg::SQ_WAITZ && en_s && !zero_s && !locked
    |=> seq == dbps_pkg::SQ_WAITZ)
    else $error("restart before output reached zero");
  // a pulse cut at soft-stop end needs up to ten cycles to reach low side
  park_a: assert property (
    soft_stop_done ##1 (!locked && armed[0] && !en_s) [*8]
    ##1 (!locked && armed[0] && !en_s) [*2]
    |-> ls_drive_ch1)
    else $error("low side not held after soft-stop");
  pg_a: assert property (
    $fell(pgood_n_oe) |-> $past(pg_cond) && seq == dbps_pkg::SQ_RUN)
    else $error("power-good released early");
endmodule
`default_nettype wire

// ---- dbps_gate_model.sv ----
// behavioural model of the external gate stages and output sense
`timescale 1ns/1ns
`default_nettype none
module dbps_gate_model #(
  parameter int ON = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hs1,
  input wire logic hs2,
  input wire logic slow,
  input wire logic fb_drop,
  input wire logic hold_nz,
  output logic duty_end_ch1,
  output logic duty_end_ch2,
  output logic fb_ok_ch1,
  output logic fb_ok_ch2,
  output logic output_level_ch1_zero
);
  int on1;
  int on2;
  int idle1;
  int idle2;
  ////////////////////////////////////////////////////////////////////////
  // on-time and idle counters; idle saturates so it never wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      on1 <= 0;
      on2 <= 0;
      idle1 <= 1000;
      idle2 <= 1000;
    end else begin
      on1 <= hs1 ? on1 + 1 : 0;
      on2 <= hs2 ? on2 + 1 : 0;
      idle1 <= hs1 ? 0 : (idle1 < 1000 ? idle1 + 1 : idle1);
      idle2 <= hs2 ? 0 : (idle2 < 1000 ? idle2 + 1 : idle2);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // slow mode never ends the pulse, so only the maximum on-time can
  assign duty_end_ch1 = hs1 && !slow && on1 >= ON;
  assign duty_end_ch2 = hs2 && !slow && on2 >= ON;
  // output counts as regulated only while its channel keeps switching
  assign fb_ok_ch1 = idle1 < 600 && !fb_drop;
  assign fb_ok_ch2 = idle2 < 600 && !fb_drop;
  assign output_level_ch1_zero = idle1 >= 300 && !hold_nz;
endmodule
`default_nettype wire

// ---- dbps_top_test.sv ----
// self-checking bench for the dual-phase buck pwm sequencer
`timescale 1ns/1ns
`default_nettype none
module dbps_top_test;
  localparam int SS = 512;
  localparam int PGD = 20;
  localparam int MXON = 40;
  localparam int ON = 20;
  typedef struct {logic ss, i1, i2, sl; int e1, e2;} dbps_row_t;
  dbps_row_t rows [5] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 2, 2},
    '{1'b1, 1'b0, 1'b0, 1'b0, 2, 2}, '{1'b0, 1'b1, 1'b0, 1'b0, 0, 2},
    '{1'b0, 1'b0, 1'b1, 1'b0, 2, 0}, '{1'b0, 1'b0, 1'b0, 1'b1, 2, 2}};
  logic clk = 0, rst = 1, en = 0, osc_in = 0, sync_ext = 0, sync_sel = 0;
  logic supply_lockout = 0, rail_discharged = 0, ilim_ch1 = 0, ilim_ch2 = 0;
  logic slow = 0, fb_drop = 0, hold_nz = 0;
  wire logic de1, de2, fb1, fb2, zero1, hs1, ls1, hs2, ls2, sw, pg_out, pg_oe;
  int err_count = 0, compares = 0;
  int r1, r2, rs, f1, ovl, h2c, l2c, l1lo, ls1e, w1, mw1, per, pc, cyc, p;
  logic p1 = 0, p2 = 0, ps = 0, hit;

  dbps_top #(.PG_DELAY(PGD), .SS_LEN(SS), .MAX_ON(MXON)) dbps_top_i (
    .clk(clk), .rst(rst), .en(en), .osc_in(osc_in), .sync_ext(sync_ext),
    .sync_sel(sync_sel), .supply_lockout(supply_lockout),
    .rail_discharged(rail_discharged), .duty_end_ch1(de1),
    .duty_end_ch2(de2), .ilim_ch1(ilim_ch1), .ilim_ch2(ilim_ch2),
    .fb_ok_ch1(fb1), .fb_ok_ch2(fb2), .output_level_ch1_zero(zero1),
    .hs_drive_ch1(hs1), .ls_drive_ch1(ls1), .hs_drive_ch2(hs2),
    .ls_drive_ch2(ls2), .sw_clk(sw), .pgood_n_out(pg_out),
    .pgood_n_oe(pg_oe));
  dbps_gate_model #(.ON(ON)) dbps_gate_model_i (
    .clk(clk), .rst(rst), .hs1(hs1), .hs2(hs2), .slow(slow),
    .fb_drop(fb_drop), .hold_nz(hold_nz), .duty_end_ch1(de1),
    .duty_end_ch2(de2), .fb_ok_ch1(fb1), .fb_ok_ch2(fb2),
    .output_level_ch1_zero(zero1));
  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock plus two unrelated switching sources
  initial forever #2 clk = ~clk;
  initial forever begin
    repeat (64) @(negedge clk);
    osc_in = ~osc_in;
  end
  initial forever begin
    repeat (48) @(negedge clk);
    sync_ext = ~sync_ext;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // steps n cycles sampling settled outputs; stop 1 hs1 rise, 2 sw rise,
  // 3 power-good release; cyc is cycles used, hit says the stop came
  task run(input int n, input int stop);
    {r1, r2, rs, f1, ovl, h2c, l2c, l1lo, ls1e, mw1, cyc} = '0;
    hit = 0;
    while (cyc < n && !hit) begin
      @(negedge clk);
      cyc++;
      hit = (stop == 1 && hs1 && !p1) || (stop == 2 && sw && !ps) ||
            (stop == 3 && pg_oe === 1'b0);
      if (hs1 && !p1) r1++;
      if (!hs1 && p1) begin
        f1++;
        if (w1 > mw1) mw1 = w1;
      end
      w1 = hs1 ? w1 + 1 : 0;
      if (hs2 && !p2) r2++;
      if (sw && !ps) begin
        rs++;
        per = pc;
        pc = 0;
      end
      pc++;
      ovl += (hs1 & ls1) | (hs2 & ls2);
      h2c += hs2;
      l2c += ls2;
      l1lo += !ls1;
      if (ls1 && f1 == 0) ls1e++;
      {p1, p2, ps} = {hs1, hs2, sw};
    end
    if (stop != 0) chk("bounded_wait", hit, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    chk("pg_reset", pg_oe, 1);
    chk("pg_data", pg_out, 0);
    @(negedge clk);
    rst = 0;
    run(8, 0);
    en = 1;
    run(SS - 20, 0);
    chk("ch2_hs_in_ss1", h2c, 0);
    chk("ch2_ls_in_ss1", l2c, 0);
    chk("ch1_started", r1 > 0, 1);
    chk("ls1_early", ls1e, 0);
    run(SS + PGD + 300, 3);
    chk("pg_delay", cyc >= SS + PGD && cyc <= SS + PGD + 40, 1);
    foreach (rows[i]) begin
      {sync_sel, ilim_ch1, ilim_ch2, slow} =
        {rows[i].ss, rows[i].i1, rows[i].i2, rows[i].sl};
      p = rows[i].ss ? 192 : 256;
      run(700, 0);
      run(1000, 2);
      run(2 * p + 4, 0);
      chk("hs1_pulses", r1, rows[i].e1);
      chk("hs2_pulses", r2, rows[i].e2);
      chk("sw_period", per, p);
      chk("overlap", ovl, 0);
      if (rows[i].i1) chk("ls1_held", l1lo, 0);
      else if (rows[i].sl) chk("max_on", mw1 >= MXON - 1 && mw1 <= MXON + 1, 1);
      else chk("duty_on", mw1 >= ON && mw1 <= ON + 5, 1);
    end
    {sync_sel, ilim_ch1, ilim_ch2, slow} = '0;
    run(1200, 3);
    fb_drop = 1;
    run(8, 0);
    chk("pg_drop", pg_oe, 1);
    fb_drop = 0;
    run(PGD + 100, 3);
    // lockout trip in full run
    supply_lockout = 1;
    run(4, 0);
    chk("lock_drives", {hs1, ls1, hs2, ls2}, 4'h0);
    run(300, 0);
    chk("lock_quiet", r1 + r2 + l2c + (300 - l1lo), 0);
    chk("lock_pg", pg_oe, 1);
    supply_lockout = 0;
    run(600, 0);
    chk("lock_latched", r1 + r2 + l2c, 0);
    rail_discharged = 1;
    run(5, 0);
    rail_discharged = 0;
    run(SS - 40, 0);
    chk("resume_ch2_off", h2c + l2c, 0);
    chk("resume_ch1", r1 > 0, 1);
    chk("resume_ls1", ls1e, 0);
    run(SS + PGD + 400, 3);
    // soft-stop, channel two first
    en = 0;
    run(SS + 30, 0);
    run(SS - 60, 0);
    chk("stop1_hs2", h2c, 0);
    chk("stop1_ls2", l2c, SS - 60);
    chk("stop1_ch1", r1 > 0, 1);
    run(100, 0);
    chk("idle_drives", {hs1, ls1, hs2, ls2}, 4'h5);
    // restart waits for output one at zero
    hold_nz = 1;
    en = 1;
    run(600, 0);
    chk("wait_zero", r1, 0);
    hold_nz = 0;
    run(800, 1);
    give_verdict;
  end
endmodule
`default_nettype wire
